// >>> src/dotl_output_terminal.sv
// Output terminal logic: digital indications, pulse counter, overload
// pre-warnings and one scaled analog output, with an AHB-Lite register slave.
// Assumes measurements and error states synchronous to hclk; the counting
// and clear pins are asynchronous.
//
// Operation
// - Code 13 follows external-fault stop error.
// - Code 14 follows any drive error.
// - Code 16 set when count equals target.
// - Code 17 set when count equals middle.
// - Arrival output when frequency difference within width.
// - Level detectors set above level, hysteretic release.
// - Each detector's hysteresis limited to its level.
// - Converter pre-warning after delayed overcurrent.
// - Converter pre-warning drops at once.
// - Motor pre-warning after delay, drops at once.
// - Pre-warning delays 0.0 to 20.0 s.
// - Counter holds until clear; target at most 9999.
// - Count flags drop on first pulse after clear.
// - Setting change clears counter and flags.
// - Analog source select routes seven sources; code 3 is reserved and gives zero.
// - Range mode picks 0-10 V or 2-10 V.
// - Gain scales output and offset.
// - Soft start error drives undervoltage output.
// - Code 10 follows DC bus undervoltage.
`timescale 1ns/1ns
module dotl_output_terminal #(
  parameter int TICK_CYCLES = dotl_pkg::TICK_CYCLES
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic      [31:0]          hrdata,
  output logic                      hresp,
  input  wire dotl_pkg::dotl_meas_s meas,
  input  wire dotl_pkg::dotl_err_s  err,
  input  wire logic                 input_function_assign_changed,
  input  wire logic                 count_pin,
  input  wire logic                 clear_pin,
  output logic [dotl_pkg::NUM_DO-1:0] digital_out,
  output logic      [13:0]          analog_out_mv
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [13:0] frac_of(input logic [15:0] val,
                                          input logic [15:0] fs);
    logic [31:0] q;
    q = 32'h0000_0000;
    if (fs == dotl_pkg::ZERO16)
      return dotl_pkg::FULL_FRAC;
    q = (32'(val) * 32'(dotl_pkg::FULL_FRAC)) / 32'(fs);
    return (q > 32'(dotl_pkg::FULL_FRAC)) ? dotl_pkg::FULL_FRAC : q[13:0];
  endfunction

  function automatic logic dout_pick(input logic [4:0] code,
      input logic [dotl_pkg::NUM_CODES-1:0] ind);
    return (32'(code) < dotl_pkg::NUM_CODES) ? ind[code] : 1'b0;
  endfunction

  // Register state
  dotl_pkg::dotl_dosel_s    dosel;
  logic [15:0]              arrival_width_setting;
  dotl_pkg::dotl_level_s    level [2];
  dotl_pkg::dotl_warn_thr_s warn_thr;
  dotl_pkg::dotl_warn_dly_s warn_dly;
  dotl_pkg::dotl_count_s    count_cfg;
  dotl_pkg::dotl_ao_s       ao_cfg;

  // Bus slave
  logic                     accept;
  logic                     wr_pend;
  logic [7:0]               wr_addr;
  logic [31:0]              rd_word;
  dotl_pkg::dotl_dosel_s    w_dosel;
  dotl_pkg::dotl_level_s    w_level;
  dotl_pkg::dotl_warn_thr_s w_thr;
  dotl_pkg::dotl_warn_dly_s w_dly;
  dotl_pkg::dotl_count_s    w_count;
  dotl_pkg::dotl_ao_s       w_ao;
  logic [13:0]              w_target;

  assign accept    = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign w_dosel   = hwdata;
  assign w_level   = hwdata;
  assign w_thr     = hwdata;
  assign w_dly     = hwdata;
  assign w_count   = hwdata;
  assign w_ao      = hwdata;
  assign w_target  = 14'(clamp16({2'b00, w_count.target}, dotl_pkg::ZERO16,
                                 dotl_pkg::TARGET_MAX));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend <= accept && hwrite;
      wr_addr <= haddr[7:0];
      hrdata  <= (accept && !hwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // Counter and indication state, read back through the status word
  logic [13:0]                   cnt;
  logic                          mid_hit;
  logic                          tgt_hit;
  logic [dotl_pkg::NUM_CODES-1:0] ind;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      dotl_pkg::REG_DOSEL:    rd_word = dosel;
      dotl_pkg::REG_ARRIVAL:  rd_word = {16'h0000, arrival_width_setting};
      dotl_pkg::REG_LEVEL1:   rd_word = level[0];
      dotl_pkg::REG_LEVEL2:   rd_word = level[1];
      dotl_pkg::REG_WARN_THR: rd_word = warn_thr;
      dotl_pkg::REG_WARN_DLY: rd_word = warn_dly;
      dotl_pkg::REG_COUNT:    rd_word = count_cfg;
      dotl_pkg::REG_ANALOG:   rd_word = ao_cfg;
      dotl_pkg::REG_STATUS:   rd_word = {ind, cnt};
      default:                rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dosel                 <= dotl_pkg::DOSEL_RESET;
      arrival_width_setting <= dotl_pkg::ARRIVAL_RESET;
      level[0]              <= dotl_pkg::LEVEL1_RESET;
      level[1]              <= dotl_pkg::LEVEL2_RESET;
      warn_thr              <= dotl_pkg::WARN_THR_RESET;
      warn_dly              <= dotl_pkg::WARN_DLY_RESET;
      count_cfg             <= dotl_pkg::COUNT_RESET;
      ao_cfg                <= dotl_pkg::AO_RESET;
    end
    else if (wr_pend)
    begin
      unique case (wr_addr)
        dotl_pkg::REG_DOSEL:
          dosel <= '{rsv1: '0, sel1: w_dosel.sel1, rsv0: '0,
                     sel0: w_dosel.sel0};
        dotl_pkg::REG_ARRIVAL:
          arrival_width_setting <= clamp16(hwdata[15:0], dotl_pkg::ZERO16,
                                           dotl_pkg::ARRIVAL_MAX);
        dotl_pkg::REG_LEVEL1:
          level[0] <= w_level;
        dotl_pkg::REG_LEVEL2:
          level[1] <= w_level;
        dotl_pkg::REG_WARN_THR:
          warn_thr <= '{rsv1: '0, rsv0: '0,
            motor: 12'(clamp16({4'h0, w_thr.motor}, dotl_pkg::MOTOR_THR_MIN,
                               dotl_pkg::MOTOR_THR_MAX)),
            conv:  12'(clamp16({4'h0, w_thr.conv}, dotl_pkg::CONV_THR_MIN,
                               dotl_pkg::CONV_THR_MAX))};
        dotl_pkg::REG_WARN_DLY:
          warn_dly <= '{rsv1: '0, rsv0: '0,
            motor: 8'(clamp16({8'h00, w_dly.motor}, dotl_pkg::ZERO16,
                              dotl_pkg::DELAY_MAX)),
            conv:  8'(clamp16({8'h00, w_dly.conv}, dotl_pkg::ZERO16,
                              dotl_pkg::DELAY_MAX))};
        dotl_pkg::REG_COUNT:
          count_cfg <= '{rsv1: '0, rsv0: '0, target: w_target,
            middle: (w_count.middle > w_target) ? w_target
                                                : w_count.middle};
        dotl_pkg::REG_ANALOG:
          ao_cfg <= '{rsv2: '0, rsv1: '0, rsv0: '0, src: w_ao.src,
            mode: w_ao.mode,
            gain: 10'(clamp16({6'h00, w_ao.gain}, dotl_pkg::ZERO16,
                              dotl_pkg::GAIN_MAX))};
        default:
          ;
      endcase
    end
  end

  // Frequency arrival and level detectors
  logic [15:0] freq_diff;
  logic        arrive;
  logic [1:0]  lvl;

  assign freq_diff = (meas.out_freq > meas.set_freq) ?
                     meas.out_freq - meas.set_freq :
                     meas.set_freq - meas.out_freq;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      arrive <= 1'b0;
    else
      arrive <= freq_diff <= arrival_width_setting;
  end

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_level
      logic [15:0] eff_hyst;
      assign eff_hyst = (level[g].hyst > level[g].thr) ? level[g].thr
                                                       : level[g].hyst;
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          lvl[g] <= 1'b0;
        else if (meas.out_freq > level[g].thr)
          lvl[g] <= 1'b1;
        else if (meas.out_freq < level[g].thr - eff_hyst)
          lvl[g] <= 1'b0;
      end
    end
  endgenerate

  // Overload pre-warnings on a shared tenth-second tick
  logic [TICK_W-1:0] tick_cnt;
  logic              tick;
  logic [1:0]        warn;
  logic [11:0]       warn_cur [2];
  logic [11:0]       warn_lvl [2];
  logic [7:0]        warn_dl  [2];

  assign tick        = tick_cnt == TICK_W'(TICK_CYCLES - 1);
  assign warn_cur[0] = meas.cur_conv;
  assign warn_cur[1] = meas.cur_motor;
  assign warn_lvl[0] = warn_thr.conv;
  assign warn_lvl[1] = warn_thr.motor;
  assign warn_dl[0]  = warn_dly.conv;
  assign warn_dl[1]  = warn_dly.motor;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tick_cnt <= '0;
    else
      tick_cnt <= tick ? '0 : tick_cnt + TICK_W'(1);
  end

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_warn
      logic [7:0] elapsed;
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          elapsed <= 8'h00;
          warn[g] <= 1'b0;
        end
        else if (warn_cur[g] <= warn_lvl[g])
        begin
          elapsed <= 8'h00;
          warn[g] <= 1'b0;
        end
        else if (elapsed >= warn_dl[g])
          warn[g] <= 1'b1;
        else if (tick)
          elapsed <= elapsed + 8'h01;
      end
    end
  endgenerate

  // Pulse counter; pins pass two flip-flops, then an edge stage
  logic [2:0] cnt_sync;
  logic [2:0] clr_sync;
  logic       count_edge;
  logic       clear_edge;
  logic       cfg_clear;
  logic       after_clear;
  logic [13:0] cnt_inc;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_sync <= 3'h0;
      clr_sync <= 3'h0;
    end
    else
    begin
      cnt_sync <= {cnt_sync[1:0], count_pin};
      clr_sync <= {clr_sync[1:0], clear_pin};
    end
  end

  assign count_edge = cnt_sync[1] && !cnt_sync[2];
  assign clear_edge = clr_sync[1] && !clr_sync[2];
  assign cfg_clear  = (wr_pend && wr_addr == dotl_pkg::REG_COUNT) ||
                      input_function_assign_changed;
  assign cnt_inc    = cnt + 14'h0001;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt         <= 14'h0000;
      mid_hit     <= 1'b0;
      tgt_hit     <= 1'b0;
      after_clear <= 1'b0;
    end
    else if (cfg_clear)
    begin
      cnt         <= 14'h0000;
      mid_hit     <= 1'b0;
      tgt_hit     <= 1'b0;
      after_clear <= 1'b0;
    end
    else if (clear_edge)
    begin
      cnt         <= 14'h0000;
      after_clear <= 1'b1;
    end
    else if (count_edge)
    begin
      if (after_clear)
      begin
        mid_hit     <= 1'b0;
        tgt_hit     <= 1'b0;
        after_clear <= 1'b0;
      end
      if (cnt != count_cfg.target)
      begin
        cnt <= cnt_inc;
        if (cnt_inc == count_cfg.middle)
          mid_hit <= 1'b1;
        if (cnt_inc == count_cfg.target)
          tgt_hit <= 1'b1;
      end
    end
  end

  // Indications by function code and per-output selection
  always_comb
  begin
    ind                          = '0;
    ind[dotl_pkg::DO_ARRIVE]     = arrive;
    ind[dotl_pkg::DO_LEVEL1]     = lvl[0];
    ind[dotl_pkg::DO_LEVEL2]     = lvl[1];
    ind[dotl_pkg::DO_UNDERVOLT]  = err.undervoltage ||
                                   err.soft_start_error;
    ind[dotl_pkg::DO_CONV_WARN]  = warn[0];
    ind[dotl_pkg::DO_MOTOR_WARN] = warn[1];
    ind[dotl_pkg::DO_EXT_STOP]   = err.ext_fault_stop_error;
    ind[dotl_pkg::DO_FAULT]      = err.any_error;
    ind[dotl_pkg::DO_TARGET]     = tgt_hit;
    ind[dotl_pkg::DO_MIDDLE]     = mid_hit;
  end

  logic [4:0] sel [dotl_pkg::NUM_DO];
  assign sel[0] = dosel.sel0;
  assign sel[1] = dosel.sel1;

  generate
    for (genvar g = 0; g < dotl_pkg::NUM_DO; g++)
    begin : g_dout
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          digital_out[g] <= 1'b0;
        else
          digital_out[g] <= dout_pick(sel[g], ind);
      end
    end
  endgenerate

  // Analog output: source fraction, then span, gain and clamp
  logic [13:0] frac;
  logic [15:0] aic_val;
  logic [31:0] base_mv;
  logic [31:0] gained_mv;

  assign aic_val = (meas.ain_curr > dotl_pkg::AIC_ZERO) ?
                   meas.ain_curr - dotl_pkg::AIC_ZERO : dotl_pkg::ZERO16;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      frac <= 14'h0000;
    else
    begin
      unique case (dotl_pkg::dotl_ao_src_e'(ao_cfg.src))
        dotl_pkg::AO_OUT_FREQ: frac <= frac_of(meas.out_freq, meas.max_freq);
        dotl_pkg::AO_SET_FREQ: frac <= frac_of(meas.set_freq, meas.max_freq);
        dotl_pkg::AO_CURRENT:
          frac <= frac_of({4'h0, meas.cur_conv}, dotl_pkg::FS_CURRENT);
        dotl_pkg::AO_RSV3:     frac <= 14'h0000;
        dotl_pkg::AO_VOLTAGE:
          frac <= frac_of({4'h0, meas.volt}, dotl_pkg::FS_RATED_1P2);
        dotl_pkg::AO_POWER:
          frac <= frac_of({4'h0, meas.power}, dotl_pkg::FS_RATED_1P2);
        dotl_pkg::AO_AIN_VOLT:
          frac <= frac_of(meas.ain_volt, dotl_pkg::FS_AIN_VOLT);
        dotl_pkg::AO_AIN_CURR:
          frac <= frac_of(aic_val, dotl_pkg::FS_AIN_CURR);
      endcase
    end
  end

  assign base_mv = ao_cfg.mode ?
    32'(dotl_pkg::OFFSET_MV) + (32'(frac) * 32'(dotl_pkg::SPAN_MV)) /
                               32'(dotl_pkg::FULL_FRAC) :
    32'(frac);
  assign gained_mv = (base_mv * 32'(ao_cfg.gain)) /
                     32'(dotl_pkg::GAIN_UNITY);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      analog_out_mv <= 14'h0000;
    else if (gained_mv > 32'(dotl_pkg::FULL_FRAC))
      analog_out_mv <= dotl_pkg::FULL_FRAC;
    else
      analog_out_mv <= gained_mv[13:0];
  end

  // Checks
  chk_ext_stop_out: assert property (@(posedge hclk) disable iff (!hresetn)
    (dosel.sel0 == dotl_pkg::DO_EXT_STOP) |=>
    digital_out[0] == $past(err.ext_fault_stop_error))
    else $error("external stop output wrong");

  chk_fault_out: assert property (@(posedge hclk) disable iff (!hresetn)
    (dosel.sel1 == dotl_pkg::DO_FAULT && err.any_error) |=>
    digital_out[1])
    else $error("fault output not set");

  chk_reserved_code: assert property (@(posedge hclk) disable iff (!hresetn)
    (dosel.sel0 == dotl_pkg::DO_RSV15) |=> !digital_out[0])
    else $error("reserved code drove output");

  chk_arrival_win: assert property (@(posedge hclk) disable iff (!hresetn)
    (freq_diff > arrival_width_setting) |=> !arrive)
    else $error("arrival outside width");

  chk_level_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (lvl[0] && meas.out_freq >= level[0].thr - g_level[0].eff_hyst)
    |=> lvl[0])
    else $error("level detector released early");

  chk_warn_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (meas.cur_conv <= warn_thr.conv) |=> !warn[0])
    else $error("pre-warning not dropped");

  chk_warn_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(warn[1]) |-> $past(meas.cur_motor) > $past(warn_thr.motor) &&
    $past(g_warn[1].elapsed) >= $past(warn_dly.motor))
    else $error("motor pre-warning early");

  chk_cfg_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_clear |=> cnt == 14'h0000 && !mid_hit && !tgt_hit)
    else $error("setting change did not clear counter");

  chk_target_stay: assert property (@(posedge hclk) disable iff (!hresetn)
    (tgt_hit && !after_clear && !cfg_clear && !clear_edge) |=>
    $stable(cnt))
    else $error("counter moved past target");

  chk_ao_zero_gain: assert property (@(posedge hclk) disable iff (!hresetn)
    (ao_cfg.gain == 10'h000)[*2] |-> analog_out_mv == 14'h0000)
    else $error("zero gain gave nonzero output");

  chk_ao_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
    analog_out_mv <= dotl_pkg::FULL_FRAC)
    else $error("analog output above full scale");

endmodule

// >>> src/dotl_pkg.sv
// Shared constants, register layouts and carriers for the output terminal
// logic. Assumes a 250 MHz AHB-Lite clock and fixed-point drive measurements.
package dotl_pkg;

  // Timing: pre-warning delays count in tenths of a second
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_MS       = 100;
  localparam int TICK_CYCLES   = TICK_MS * 1_000_000 / CLK_PERIOD_NS;

  localparam int NUM_DO    = 2;
  localparam int NUM_CODES = 18;

  // Register byte offsets
  localparam logic [7:0] REG_DOSEL    = 8'h00;
  localparam logic [7:0] REG_ARRIVAL  = 8'h04;
  localparam logic [7:0] REG_LEVEL1   = 8'h08;
  localparam logic [7:0] REG_LEVEL2   = 8'h0c;
  localparam logic [7:0] REG_WARN_THR = 8'h10;
  localparam logic [7:0] REG_WARN_DLY = 8'h14;
  localparam logic [7:0] REG_COUNT    = 8'h18;
  localparam logic [7:0] REG_ANALOG   = 8'h1c;
  localparam logic [7:0] REG_STATUS   = 8'h20;

  // Setting limits (0.01 Hz, 0.1 %, 0.1 s, counts, mV, 0.01 gain)
  localparam logic [15:0] ARRIVAL_MAX   = 16'h9c40;
  localparam logic [15:0] CONV_THR_MIN  = 16'h00c8;
  localparam logic [15:0] CONV_THR_MAX  = 16'h07d0;
  localparam logic [15:0] MOTOR_THR_MIN = 16'h03e8;
  localparam logic [15:0] MOTOR_THR_MAX = 16'h09c4;
  localparam logic [15:0] DELAY_MAX     = 16'h00c8;
  localparam logic [15:0] TARGET_MAX    = 16'h270f;
  localparam logic [15:0] GAIN_MAX      = 16'h03e8;
  localparam logic [15:0] ZERO16        = 16'h0000;

  // Analog scaling
  localparam logic [13:0] FULL_FRAC    = 14'h2710;
  localparam logic [13:0] OFFSET_MV    = 14'h07d0;
  localparam logic [13:0] SPAN_MV      = 14'h1f40;
  localparam logic [15:0] FS_CURRENT   = 16'h07d0;
  localparam logic [15:0] FS_RATED_1P2 = 16'h04b0;
  localparam logic [15:0] FS_AIN_VOLT  = 16'h03e8;
  localparam logic [15:0] AIC_ZERO     = 16'h0190;
  localparam logic [15:0] FS_AIN_CURR  = 16'h0640;
  localparam logic [15:0] GAIN_UNITY   = 16'h0064;

  typedef enum logic [4:0] {
    DO_ARRIVE     = 5'h04,
    DO_LEVEL1     = 5'h05,
    DO_LEVEL2     = 5'h06,
    DO_UNDERVOLT  = 5'h0a,
    DO_CONV_WARN  = 5'h0b,
    DO_MOTOR_WARN = 5'h0c,
    DO_EXT_STOP   = 5'h0d,
    DO_FAULT      = 5'h0e,
    DO_RSV15      = 5'h0f,
    DO_TARGET     = 5'h10,
    DO_MIDDLE     = 5'h11
  } dotl_code_e;

  typedef enum logic [2:0] {
    AO_OUT_FREQ = 3'h0,
    AO_SET_FREQ = 3'h1,
    AO_CURRENT  = 3'h2,
    AO_RSV3     = 3'h3,
    AO_VOLTAGE  = 3'h4,
    AO_POWER    = 3'h5,
    AO_AIN_VOLT = 3'h6,
    AO_AIN_CURR = 3'h7
  } dotl_ao_src_e;

  typedef struct packed {
    logic [18:0] rsv1;
    logic [4:0]  sel1;
    logic [2:0]  rsv0;
    logic [4:0]  sel0;
  } dotl_dosel_s;

  typedef struct packed {
    logic [15:0] hyst;
    logic [15:0] thr;
  } dotl_level_s;

  typedef struct packed {
    logic [3:0]  rsv1;
    logic [11:0] motor;
    logic [3:0]  rsv0;
    logic [11:0] conv;
  } dotl_warn_thr_s;

  typedef struct packed {
    logic [7:0] rsv1;
    logic [7:0] motor;
    logic [7:0] rsv0;
    logic [7:0] conv;
  } dotl_warn_dly_s;

  typedef struct packed {
    logic [1:0]  rsv1;
    logic [13:0] target;
    logic [1:0]  rsv0;
    logic [13:0] middle;
  } dotl_count_s;

  typedef struct packed {
    logic [5:0] rsv2;
    logic [9:0] gain;
    logic [6:0] rsv1;
    logic       mode;
    logic [4:0] rsv0;
    logic [2:0] src;
  } dotl_ao_s;

  // Drive measurements: frequencies 0.01 Hz, ratios 0.1 % of rated,
  // voltage input 0.01 V, current input 0.01 mA
  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] set_freq;
    logic [15:0] max_freq;
    logic [11:0] cur_conv;
    logic [11:0] cur_motor;
    logic [11:0] volt;
    logic [11:0] power;
    logic [15:0] ain_volt;
    logic [15:0] ain_curr;
  } dotl_meas_s;

  typedef struct packed {
    logic ext_fault_stop_error;
    logic any_error;
    logic undervoltage;
    logic soft_start_error;
  } dotl_err_s;

  localparam dotl_dosel_s DOSEL_RESET =
    '{rsv1: 19'h0_0000, sel1: 5'h01, rsv0: 3'h0, sel0: 5'h01};
  localparam logic [15:0] ARRIVAL_RESET = 16'h00fa;
  localparam dotl_level_s LEVEL1_RESET = '{hyst: 16'h0064, thr: 16'h1388};
  localparam dotl_level_s LEVEL2_RESET = '{hyst: 16'h0064, thr: 16'h09c4};
  localparam dotl_warn_thr_s WARN_THR_RESET =
    '{rsv1: 4'h0, motor: 12'h3e8, rsv0: 4'h0, conv: 12'h44c};
  localparam dotl_warn_dly_s WARN_DLY_RESET =
    '{rsv1: 8'h00, motor: 8'h14, rsv0: 8'h00, conv: 8'h14};
  localparam dotl_count_s COUNT_RESET =
    '{rsv1: 2'h0, target: 14'h0000, rsv0: 2'h0, middle: 14'h0000};
  localparam dotl_ao_s AO_RESET =
    '{rsv2: 6'h00, gain: 10'h064, rsv1: 7'h00, mode: 1'b0, rsv0: 5'h00,
      src: 3'h0};

endpackage

// >>> bench/dotl_terminal_model.sv
// External terminal side: makes counting and clear-counting pulses.
// Assumes the bench calls pulse() from its main sequence.
`timescale 1ns/1ns
module dotl_terminal_model #(
  parameter int PH = 8
) (
  input  wire logic hclk,
  output logic      count_pin,
  output logic      clear_pin
);
  initial
  begin
    count_pin = 1'b0;
    clear_pin = 1'b0;
  end
  // High and low phases each last PH cycles
  task automatic pulse(input bit clr);
    @(posedge hclk);
    if (clr)
      clear_pin <= 1'b1;
    else
      count_pin <= 1'b1;
    repeat (PH) @(posedge hclk);
    clear_pin <= 1'b0;
    count_pin <= 1'b0;
    repeat (PH) @(posedge hclk);
  endtask
endmodule

// >>> bench/dotl_output_terminal_tb.sv
// Self-checking bench for the output terminal logic.
// Assumes a zero-wait AHB-Lite slave and a shortened delay tick.
`timescale 1ns/1ns
module dotl_output_terminal_tb;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ifa;
  logic [31:0] haddr, hwdata, hrdata, r, seed;
  logic [1:0]  htrans, dout;
  logic [2:0]  hsize;
  logic [13:0] aout;
  wire         cpin, kpin;
  dotl_pkg::dotl_meas_s meas;
  dotl_pkg::dotl_err_s  err;
  int          n_mismatch, n_checks, cyc, cnt, a, g, m;
  bit          fm, ft, kf;
  logic [1:0]  ex[4] = '{2'b01, 2'b11, 2'b10, 2'b00};
  int          fq[4] = '{5001, 4950, 4899, 5000};
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  dotl_output_terminal #(.TICK_CYCLES(10)) dut (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hrdata, .hresp, .meas, .err, .input_function_assign_changed(ifa),
    .count_pin(cpin), .clear_pin(kpin), .digital_out(dout),
    .analog_out_mv(aout));
  dotl_terminal_model p (.hclk, .count_pin(cpin), .clear_pin(kpin));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
    @(posedge hclk);
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic bus(bit w, logic [7:0] ad, logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite} <= {3'b110, w};
    haddr <= {24'h00_0000, ad};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans} <= 3'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int ao(int a, int m, int g);
    int v;
    v = m ? 2000 + a * 8 : a * 10;
    v = v * g / 100;
    return v > 10000 ? 10000 : v;
  endfunction
  task automatic count_one();
    p.pulse(1'b0);
    if (kf)
      {kf, fm, ft, cnt} = '0;
    if (cnt < 3)
      cnt++;
    fm |= (cnt == 2);
    ft |= (cnt == 3);
    settle(0);
    chk("count flags", {fm, ft}, dout);
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  initial
  begin
    {hclk, hresetn, hsel, hwrite, ifa, htrans} = '0;
    {haddr, hwdata, meas, err} = '0;
    hsize = 3'h2;
    seed = 32'h0000_d780;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, dotl_pkg::REG_DOSEL, 0);
    chk("dosel reset", 32'h0000_0101, r);
    chk("ahb okay", 0, {hresp, !hreadyout});
    bus(0, 8'h3c, 0);
    chk("unmapped", 0, r);
    for (int k = 0; k < 2; k++)
    begin
      bus(1, dotl_pkg::REG_DOSEL, k ? 32'h0000_0a0f : 32'h0000_0e0d);
      for (int i = 0; i < 16; i++)
      begin
        err <= i[3:0];
        settle(3);
        chk("err", k ? {i[1] | i[0], 1'b0} : {i[2], i[3]}, dout);
      end
    end
    err <= '0;
    $display("test error codes done");
    bus(1, dotl_pkg::REG_DOSEL, 32'h0000_0405);
    meas.set_freq <= 16'h125c;
    for (int i = 0; i < 4; i++)
    begin
      meas.out_freq <= fq[i][15:0];
      settle(5);
      chk("freq detect", ex[i], dout);
    end
    $display("test frequency done");
    bus(1, dotl_pkg::REG_DOSEL, 32'h0000_0c0b);
    bus(1, dotl_pkg::REG_WARN_DLY, 32'h0000_0003);
    meas.cur_conv <= 12'h4b0;
    meas.cur_motor <= 12'h44c;
    settle(12);
    chk("warn early", 2'b10, dout);
    settle(40);
    chk("warn late", 2'b11, dout);
    meas.cur_conv <= 12'h3e8;
    settle(2);
    chk("warn drop", 2'b10, dout);
    $display("test prewarning done");
    for (int i = 0; i < 6; i++)
    begin
      a = rnd() % 1001;
      g = rnd() % 1001;
      m = rnd() % 2;
      if (i == 5)
        g = 0;
      meas.ain_volt <= a[15:0];
      bus(1, dotl_pkg::REG_ANALOG, {6'h00, g[9:0], 7'h00, m[0], 8'h06});
      settle(4);
      chk("analog", ao(a, m, g), aout);
    end
    meas.out_freq <= 16'h1388;
    meas.max_freq <= 16'h2710;
    bus(1, dotl_pkg::REG_ANALOG, 32'h01f4_0100);
    settle(4);
    chk("ao source 0", ao(500, 1, 500), aout);
    $display("test analog done");
    bus(1, dotl_pkg::REG_DOSEL, 32'h0000_1110);
    bus(1, dotl_pkg::REG_COUNT, 32'h0003_0002);
    repeat (4) count_one();
    bus(0, dotl_pkg::REG_STATUS, 0);
    chk("count hold", 3, r[13:0]);
    p.pulse(1'b1);
    kf = 1'b1;
    settle(0);
    chk("after clear", 2'b11, dout);
    repeat (2) count_one();
    bus(1, dotl_pkg::REG_COUNT, 32'h0003_0002);
    settle(1);
    chk("config clear", 0, dout);
    {cnt, fm, ft} = '0;
    repeat (2) count_one();
    ifa <= 1'b1;
    @(posedge hclk);
    ifa <= 1'b0;
    settle(1);
    chk("assign clear", 0, dout);
    $display("test counter done");
    end_sim();
  end
endmodule
